// file: design/nic_top.v
// Purpose: nested prioritised interrupt controller for an 8-bit core
// Assumes: core sequencer samples request only at instruction boundaries
// Notes: software priority levels are ranked 0..3 internally
// Summary of operation
// - Four nesting levels, fourteen vectors plus traps
// - Current priority held in CC bits five, three
// - Vectors at top of memory, hardware ordered
// - Encodings 10,01,00,11 for levels zero..three
// - Finish instruction, then stack PC, X, A, CC
// - Load priority from vector field, then vector
// - Return restores stacked priority bits
// - Highest software priority, then hardware priority wins
// - Unserviced requests stay latched until highest or cleared
// - Reset, trap, emergency stop rank highest
// - Non-maskable ignore level, set level three
// - Non-maskable sources leave Halt
// - Trap follows emergency stop service flow
// - Reset highest; first routine runs level three
// - Maskable needs enable and higher priority
// - Emergency stop by edge or error, level holds
// - Edge requests latched, cleared on entry, ORed
// - Peripheral request is flag and enable
// - Eligible or fixed request wakes Wait; Halt exit needs capability or fixed source
// - Non-capable pending request follows the first
// - Fixed hardware order; no stack overflow detection
// - Level-zero pattern writes are ignored per field
// - Priority registers reset to all ones
`include "nic_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module nic_top (
  // CPU clock
  input wire clk_in,
  // Asynchronous reset, active low
  input wire rst_b_in,
  // Sensed edge events per slot
  input wire [13:0] ext_edge_in,
  // Level requests per slot
  input wire [13:0] ext_level_in,
  // Peripheral status flags
  input wire [13:0] periph_flag_in,
  // Peripheral enable bits
  input wire [13:0] periph_en_in,
  // Software clear of edge latches
  input wire [13:0] src_clear_in,
  // Slots able to leave Halt
  input wire [13:0] halt_wake_cap_in,
  // Emergency stop pin, active low
  input wire estop_pin_b_in,
  // Speed measurement error pulse
  input wire speed_err_in,
  // Emergency stop level enable
  input wire emergency_irq_enable_in,
  // Trap instruction executed
  input wire trap_in,
  // Priority register write strobe
  input wire prio_wr_in,
  // Priority register index
  input wire [1:0] prio_idx_in,
  // Priority register write data
  input wire [7:0] prio_wdata_in,
  // Software condition-code write
  input wire cc_wr_in,
  // Condition-code write data
  input wire [7:0] cc_wdata_in,
  // Core accepts the offer
  input wire ack_in,
  // Core finished stacking
  input wire stack_done_in,
  // Return instruction executed
  input wire return_from_interrupt_in,
  // Condition codes popped on return
  input wire [7:0] return_from_interrupt_cc_in,
  // Core enters Halt
  input wire halt_in,
  // Core enters Wait
  input wire wait_in,
  // Request offered to the core
  output reg irq_req_out,
  // Vector of the offered request
  output reg [15:0] vector_out,
  // Stacking in progress
  output reg stack_ctx_out,
  // Condition-code copy
  output reg [7:0] cc_out,
  // All priority registers
  output reg [31:0] prio_regs_out,
  // Live requests per slot
  output reg [13:0] pending_out,
  // Core halted
  output reg halted_out,
  // Core waiting
  output reg waiting_out,
  // Wake condition seen
  output reg wake_out
);
  // Rank 0 is main level, rank 3 is disabled
  function [1:0] lvl_rank;
    input [1:0] enc;
    begin
      case (enc)
        `NIC_LVL0: lvl_rank = `NIC_RANK0;
        `NIC_LVL1: lvl_rank = `NIC_RANK1;
        `NIC_LVL2: lvl_rank = `NIC_RANK2;
        default: lvl_rank = `NIC_RANK3;
      endcase
    end
  endfunction

  reg [7:0] prio_reg [0:3]; // Per-vector priority registers
  reg [7:0] cc_reg; // Condition-code copy
  reg [13:0] latch_reg; // Latched edge requests
  reg estop_reg; // Latched emergency stop edge
  reg estop_pin_d_reg; // Pin history for edge detect
  reg trap_reg; // Pending trap
  reg reset_pend_reg; // First routine after reset
  reg [1:0] state_reg; // Service sequencer state
  reg [1:0] kind_reg; // Kind being serviced
  reg [3:0] sel_reg; // Selected maskable slot
  reg [1:0] new_lvl_reg; // Level to load on entry
  reg halt_reg; // Core halted
  reg wait_reg; // Core waiting
  reg halt_first_reg; // First service after Halt exit

  wire [13:0] req; // Live requests per slot
  wire [27:0] field; // Priority fields flattened
  wire [1:0] cur_rank;
  wire estop_req;
  reg [13:0] elig;
  reg found;
  reg [3:0] best;
  reg [1:0] best_rank;
  integer i; // Arbitration loop index
  integer j; // Priority write loop index, own process
  genvar g;

  // Two bits of each field, slot g at bits 2g+1:2g
  generate
    for (g = 0; g < `NIC_NUM_SRC; g = g + 1) begin : fld
      assign field[2*g+1:2*g] = prio_reg[g/4][2*(g%4)+1:2*(g%4)];
      // Edge latch ORed with flag-and-enable
      assign req[g] = latch_reg[g] | ext_level_in[g] |
                      (periph_flag_in[g] & periph_en_in[g]);
    end
  endgenerate

  assign cur_rank = lvl_rank({cc_reg[`NIC_CC_HI_BIT],
                              cc_reg[`NIC_CC_LO_BIT]});
  // Edge or error, held while pin low and enabled
  assign estop_req = estop_reg |
                     (emergency_irq_enable_in & ~estop_pin_b_in);

  // Arbitration: higher rank first, lower slot breaks ties
  always @* begin
    found = 1'b0;
    best = 4'h0;
    best_rank = `NIC_RANK0;
    for (i = 0; i < `NIC_NUM_SRC; i = i + 1) begin
      // Needs a request above the current level
      elig[i] = req[i] & (lvl_rank(field[2*i+1 -: 2]) > cur_rank) &
                (~halt_first_reg | halt_wake_cap_in[i]);
    end
    for (i = `NIC_NUM_SRC - 1; i >= 0; i = i - 1) begin
      if (elig[i] && (!found ||
          lvl_rank(field[2*i+1 -: 2]) >= best_rank)) begin
        found = 1'b1;
        best = i[3:0];
        best_rank = lvl_rank(field[2*i+1 -: 2]);
      end
    end
  end

  // Priority registers with level-zero write guard
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      for (j = 0; j < `NIC_PRIO_REG_N; j = j + 1) begin
        prio_reg[j] <= `NIC_PRIO_RST;
      end
    end else if (prio_wr_in) begin
      for (j = 0; j < `NIC_PRIO_REG_N; j = j + 1) begin
        // Keep old field when level-zero code is written
        if (prio_wdata_in[2*j+1 -: 2] != `NIC_LVL0) begin
          prio_reg[prio_idx_in][2*j+1 -: 2] <= prio_wdata_in[2*j+1 -: 2];
        end
      end
    end
  end

  // Request latches, halt and wait tracking
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      latch_reg <= 14'h0000;
      estop_reg <= 1'b0;
      estop_pin_d_reg <= 1'b1;
      trap_reg <= 1'b0;
      halt_reg <= 1'b0;
      wait_reg <= 1'b0;
    end else begin
      estop_pin_d_reg <= estop_pin_b_in;
      // Set wins over entry clear and software clear
      latch_reg <= (latch_reg & ~src_clear_in &
                    ~((state_reg == `NIC_ST_STACK && stack_done_in &&
                       kind_reg == `NIC_KIND_MASK) ?
                      (14'h0001 << sel_reg) : 14'h0000)) |
                   ext_edge_in;
      if ((estop_pin_d_reg & ~estop_pin_b_in) | speed_err_in) begin
        estop_reg <= 1'b1;
      end else if (state_reg == `NIC_ST_STACK && stack_done_in &&
                   kind_reg == `NIC_KIND_ESTOP) begin
        estop_reg <= 1'b0;
      end
      if (trap_in) begin
        trap_reg <= 1'b1;
      end else if (state_reg == `NIC_ST_STACK && stack_done_in &&
                   kind_reg == `NIC_KIND_TRAP) begin
        trap_reg <= 1'b0;
      end
      // Eligible maskable or fixed request ends Wait; Halt needs wake-capable or fixed source
      if (wait_in) begin
        wait_reg <= 1'b1;
      end else if (found | estop_req | trap_reg) begin
        wait_reg <= 1'b0;
      end
      if (halt_in) begin
        halt_reg <= 1'b1;
      end else if (estop_req | trap_reg |
                   (|(req & halt_wake_cap_in))) begin
        halt_reg <= 1'b0;
      end
    end
  end

  // Service sequencer: offer, acknowledge, stack, enter
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      state_reg <= `NIC_ST_REQ;
      kind_reg <= `NIC_KIND_RESET;
      reset_pend_reg <= 1'b1;
      sel_reg <= 4'h0;
      new_lvl_reg <= `NIC_LVL3;
      cc_reg <= `NIC_CC_RST;
      halt_first_reg <= 1'b0;
    end else begin
      // Halt entry forces level 0 until woken
      if (halt_in) begin
        halt_first_reg <= 1'b1;
        cc_reg[`NIC_CC_HI_BIT] <= 1'b1;
        cc_reg[`NIC_CC_LO_BIT] <= 1'b0;
      end else if (return_from_interrupt_in) begin
        cc_reg <= return_from_interrupt_cc_in;
      end else if (cc_wr_in) begin
        cc_reg <= cc_wdata_in;
      end
      case (state_reg)
        `NIC_ST_IDLE: begin
          // Fixed sources outrank every maskable one
          if (estop_req) begin
            state_reg <= `NIC_ST_REQ;
            kind_reg <= `NIC_KIND_ESTOP;
            new_lvl_reg <= `NIC_LVL3;
          end else if (trap_reg) begin
            state_reg <= `NIC_ST_REQ;
            kind_reg <= `NIC_KIND_TRAP;
            new_lvl_reg <= `NIC_LVL3;
          end else if (found && !halt_reg) begin
            state_reg <= `NIC_ST_REQ;
            kind_reg <= `NIC_KIND_MASK;
            sel_reg <= best;
            new_lvl_reg <= field[2*best+1 -: 2];
          end
        end
        `NIC_ST_REQ: begin
          if (ack_in) begin
            // Reset skips stacking
            state_reg <= (kind_reg == `NIC_KIND_RESET) ?
                         `NIC_ST_IDLE : `NIC_ST_STACK;
            if (kind_reg == `NIC_KIND_RESET) begin
              reset_pend_reg <= 1'b0;
              cc_reg[`NIC_CC_HI_BIT] <= 1'b1;
              cc_reg[`NIC_CC_LO_BIT] <= 1'b1;
            end
          end
        end
        `NIC_ST_STACK: begin
          if (stack_done_in) begin
            state_reg <= `NIC_ST_IDLE;
            // Cleared by the first completed service of any kind
            halt_first_reg <= 1'b0;
            cc_reg[`NIC_CC_HI_BIT] <= new_lvl_reg[1];
            cc_reg[`NIC_CC_LO_BIT] <= new_lvl_reg[0];
          end
        end
        default: begin
          // Unused code falls back to idle
          state_reg <= `NIC_ST_IDLE;
        end
      endcase
    end
  end

  // Vector address: fixed top slots then descending by slot
  always @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      irq_req_out <= 1'b0;
      vector_out <= `NIC_VEC_RESET;
      stack_ctx_out <= 1'b0;
      cc_out <= `NIC_CC_RST;
      prio_regs_out <= {4{`NIC_PRIO_RST}};
      pending_out <= 14'h0000;
      halted_out <= 1'b0;
      waiting_out <= 1'b0;
      wake_out <= 1'b0;
    end else begin
      // Offer withdrawn on the acceptance edge
      irq_req_out <= (state_reg == `NIC_ST_REQ) & ~ack_in;
      case (kind_reg)
        `NIC_KIND_RESET: vector_out <= `NIC_VEC_RESET;
        `NIC_KIND_TRAP: vector_out <= `NIC_VEC_TRAP;
        `NIC_KIND_ESTOP: vector_out <= `NIC_VEC_ESTOP;
        default: vector_out <= `NIC_VEC_BASE -
                              {11'h000, sel_reg, 1'b0};
      endcase
      // Stacking flag drops with completion
      stack_ctx_out <= (state_reg == `NIC_ST_STACK) & ~stack_done_in;
      // Level shows one cycle after loading
      cc_out <= cc_reg;
      // Highest register in the top byte
      prio_regs_out <= {prio_reg[3], prio_reg[2], prio_reg[1], prio_reg[0]};
      // Live view, entry clears show next cycle
      pending_out <= req;
      halted_out <= halt_reg;
      waiting_out <= wait_reg;
      // No stack overflow flag exists by design
      wake_out <= (halt_reg | wait_reg) &
                  ~(halt_in | wait_in) & (found | estop_req | trap_reg);
    end
  end
endmodule // nic_top
`default_nettype wire

// file: design/nic_consts.vh
// Purpose: constants for the nested interrupt controller
// Assumes: plain Verilog-2005 include
// Notes: vector slot 0 is the highest hardware priority maskable slot
`ifndef NIC_CONSTS_VH
`define NIC_CONSTS_VH
`define NIC_NUM_SRC 14
`define NIC_SRC_W 4
`define NIC_LVL_W 2
`define NIC_LVL0 2'h2
`define NIC_LVL1 2'h1
`define NIC_LVL2 2'h0
`define NIC_LVL3 2'h3
`define NIC_RANK0 2'h0
`define NIC_RANK1 2'h1
`define NIC_RANK2 2'h2
`define NIC_RANK3 2'h3
`define NIC_PRIO_RST 8'hff
`define NIC_PRIO_REG_N 4
`define NIC_CC_RST 8'hea
`define NIC_CC_HI_BIT 5
`define NIC_CC_LO_BIT 3
`define NIC_VEC_RESET 16'hfffe
`define NIC_VEC_TRAP 16'hfffc
`define NIC_VEC_ESTOP 16'hfffa
`define NIC_VEC_BASE 16'hfff8
`define NIC_VEC_TOP 16'hffe0
`define NIC_VEC_STEP 16'h0002
`define NIC_ST_IDLE 2'h0
`define NIC_ST_REQ 2'h1
`define NIC_ST_STACK 2'h2
`define NIC_KIND_MASK 2'h0
`define NIC_KIND_TRAP 2'h1
`define NIC_KIND_ESTOP 2'h2
`define NIC_KIND_RESET 2'h3
`endif

// file: tb/nic_monitor.sv
// Purpose: port-level checker for the nested interrupt controller
// Assumes: sees only nic_top ports, one clock domain
// Notes: bound to every nic_top instance at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module nic_monitor (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic ack_in,
  input wire logic stack_done_in,
  input wire logic return_from_interrupt_in,
  input wire logic [7:0] return_from_interrupt_cc_in,
  input wire logic prio_wr_in,
  input wire logic [1:0] prio_idx_in,
  input wire logic [7:0] prio_wdata_in,
  input wire logic irq_req_out,
  input wire logic [15:0] vector_out,
  input wire logic stack_ctx_out,
  input wire logic [7:0] cc_out,
  input wire logic [31:0] prio_regs_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rst_b_in);
  // Core takes the offered request
  sequence accept_s; irq_req_out && ack_in && vector_out != 16'hfffe; endsequence
  // Stacking shows two edges on and the offer is withdrawn
  sequence stack_s; ##2 stack_ctx_out && !irq_req_out; endsequence
  ack_stack_a: assert property (accept_s |-> stack_s)
    else $error("stacking did not follow acceptance");
  vec_hold_a: assert property (irq_req_out && !ack_in |=>
    irq_req_out && $stable(vector_out))
    else $error("offer dropped or vector moved before acceptance");
  vec_range_a: assert property (irq_req_out |-> vector_out >= 16'hffe0)
    else $error("vector below the vector table");
  // Level 3 blocks every maskable source
  mask_lvl_a: assert property ($rose(irq_req_out) && cc_out[5] && cc_out[3] |->
    vector_out inside {16'hfffe, 16'hfffc, 16'hfffa})
    else $error("maskable source offered at level 3");
  nmi_lvl_a: assert property (stack_ctx_out && stack_done_in &&
    vector_out inside {16'hfffc, 16'hfffa} |-> ##2 cc_out[5] && cc_out[3])
    else $error("top level source did not set level 3");
  done_end_a: assert property (stack_ctx_out && stack_done_in |=> !stack_ctx_out)
    else $error("stacking did not end on completion");
  return_from_interrupt_cc_a: assert property (return_from_interrupt_in |-> ##2 cc_out == $past(return_from_interrupt_cc_in, 2))
    else $error("return did not restore the condition codes");
  // A level 0 pattern leaves the old field in place
  prio_keep_a: assert property (prio_wr_in && prio_idx_in == 2'h0 &&
    prio_wdata_in[5:4] == 2'h2 |=> ##1 prio_regs_out[5:4] == $past(prio_regs_out[5:4]))
    else $error("level 0 pattern was stored");
endmodule // nic_monitor
bind nic_top nic_monitor mon (.*);
`default_nettype wire

// file: tb/nic_core_model.sv
// Purpose: behavioural core sequencer facing the controller
// Assumes: acceptance and stacking each take DLY+1 cycles
// Notes: a larger DLY models a slow, multi-cycle instruction
`timescale 1ns/1ps
`default_nettype none
module nic_core_model #(parameter int DLY = 2) (
  input wire logic clk_in,
  input wire logic rst_b_in,
  input wire logic irq_req_out,
  input wire logic stack_ctx_out,
  output var logic ack_in,
  output var logic stack_done_in
);
  logic [3:0] cnt_reg; // Cycles spent finishing the current step
  // Accept only at an instruction boundary, then stack context
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      cnt_reg <= 4'h0;
      ack_in <= 1'b0;
      stack_done_in <= 1'b0;
    end else begin
      ack_in <= 1'b0;
      stack_done_in <= 1'b0;
      if ((irq_req_out && !ack_in) || (stack_ctx_out && !stack_done_in)) begin
        cnt_reg <= cnt_reg + 4'h1;
        if (cnt_reg == DLY[3:0]) begin
          cnt_reg <= 4'h0;
          ack_in <= irq_req_out;
          stack_done_in <= stack_ctx_out;
        end
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule // nic_core_model
`default_nettype wire

// file: tb/nic_top_tb.sv
// Purpose: directed testbench for the interrupt controller
// Assumes: core model answers every offer
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
`default_nettype none
module nic_top_tb;
  logic clk_in = 1'b0, rst_b_in = 1'b0, estop_pin_b_in = 1'b1;
  logic speed_err_in = 1'b0, emergency_irq_enable_in = 1'b0, trap_in = 1'b0;
  logic [13:0] ext_edge_in = '0, ext_level_in = '0, periph_flag_in = '0;
  logic [13:0] periph_en_in = '0, src_clear_in = '0, halt_wake_cap_in = '0;
  logic prio_wr_in = 1'b0, cc_wr_in = 1'b0, return_from_interrupt_in = 1'b0;
  logic halt_in = 1'b0, wait_in = 1'b0, ack_in, stack_done_in;
  logic [1:0] prio_idx_in = 2'h0;
  logic [7:0] prio_wdata_in = 8'h00, cc_wdata_in = 8'h00, return_from_interrupt_cc_in = 8'h00;
  logic irq_req_out, stack_ctx_out, halted_out, waiting_out, wake_out;
  logic [15:0] vector_out;
  logic [7:0] cc_out;
  logic [31:0] prio_regs_out;
  logic [13:0] pending_out;
  int n_fail = 0, checks_done = 0, cyc = 0;
  nic_top dut (.*);
  nic_core_model #(.DLY(2)) core (.*);
  always #2 clk_in = ~clk_in;
  // Cut a hang short
  always @(posedge clk_in) begin
    cyc++;
    if (cyc == 3000) begin
      n_fail++;
      give_verdict();
    end
  end
  task automatic step(); @(posedge clk_in); #1; endtask
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Wait for an offer, check its vector, let the core service it
  task automatic serve(logic [15:0] v);
    int i;
    i = 0;
    while (irq_req_out !== 1'b1 && i < 40) begin step(); i++; end
    check("vector", vector_out, v);
    while (irq_req_out === 1'b1 && i < 80) begin step(); i++; end
    // Reset entry has no stacking phase
    if (v != 16'hfffe) begin
      while (stack_ctx_out !== 1'b1 && i < 120) begin step(); i++; end
      while (stack_ctx_out === 1'b1 && i < 160) begin step(); i++; end
    end
    // Let the new level reach the condition-code output
    step();
  endtask
  task automatic ret(logic [7:0] c);
    return_from_interrupt_in = 1'b1; return_from_interrupt_cc_in = c; step(); return_from_interrupt_in = 1'b0; step();
  endtask
  task automatic t_reset();
    check("prio", prio_regs_out, 32'hffffffff);
    serve(16'hfffe);
    check("level", {cc_out[5], cc_out[3]}, 2'h3);
    prio_wr_in = 1'b1; prio_wdata_in = 8'hcf; step();
    prio_wdata_in = 8'h64; step(); prio_wr_in = 1'b0; step();
    check("prio0", prio_regs_out[7:0], 8'h44);
    $display("reset and priority test done");
  endtask
  // Slot 3 at level 1 waits while the core sits at level 3
  task automatic t_mask();
    periph_flag_in[3] = 1'b1; periph_en_in[3] = 1'b1; repeat (6) step();
    check("masked", irq_req_out, 1'b0);
    check("pend3", pending_out[3], 1'b1);
    cc_wr_in = 1'b1; cc_wdata_in = 8'he2; step(); cc_wr_in = 1'b0;
    serve(16'hfff2);
    check("level", {cc_out[5], cc_out[3]}, 2'h1);
    periph_flag_in[3] = 1'b0; ret(8'he2);
    check("cc", cc_out, 8'he2);
    $display("mask test done");
  endtask
  // Software level decides before hardware order
  task automatic t_arb();
    ext_edge_in = 14'h0012; step(); ext_edge_in = '0;
    serve(16'hfff0);
    check("pend", {pending_out[4], pending_out[1]}, 2'h1);
    src_clear_in[1] = 1'b1; step(); src_clear_in = '0;
    ret(8'he2); repeat (4) step();
    check("cleared", {irq_req_out, pending_out[1]}, 2'h0);
    $display("arbitration test done");
  endtask
  // Top level first, then hardware order at equal level 2
  task automatic t_estop();
    ext_edge_in = 14'h0005; speed_err_in = 1'b1; step();
    ext_edge_in = '0; speed_err_in = 1'b0;
    serve(16'hfffa);
    check("level", {cc_out[5], cc_out[3]}, 2'h3);
    ret(8'he2); serve(16'hfff8);
    ret(8'he2); serve(16'hfff4);
    ret(8'he2);
    halt_in = 1'b1; step(); halt_in = 1'b0; step();
    check("halted", halted_out, 1'b1);
    trap_in = 1'b1; step(); trap_in = 1'b0;
    serve(16'hfffc);
    check("woken", halted_out, 1'b0);
    check("level", {cc_out[5], cc_out[3]}, 2'h3);
    ret(8'he2);
    wait_in = 1'b1; step(); wait_in = 1'b0; step();
    check("waiting", waiting_out, 1'b1);
    ext_edge_in[0] = 1'b1; step(); ext_edge_in = '0; step();
    check("wake", wake_out, 1'b1);
    serve(16'hfff8);
    check("awake", waiting_out, 1'b0);
    ret(8'he2);
    $display("top level test done");
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  initial begin
    repeat (8) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    t_reset();
    t_mask();
    t_arb();
    t_estop();
    give_verdict();
  end
endmodule // nic_top_tb
`default_nettype wire
